// *** logic/csa_status_alert.sv ***
// charger status word with open-drain host alert and host read port
`timescale 1ns/1ps
`default_nettype none
module csa_status_alert
    import csa_pkg::*;
#(
    parameter int DEGLITCH_CYCLES = DEGLITCH_CYC  // shorten in simulation
) (
    // system clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // charger conditions, asynchronous levels
    input  wire logic        por_done,            // power-on reset finished
    input  wire logic        adapter_det,         // adapter present
    input  wire logic        gate_drive_rail,     // gate-drive rail ready
    input  wire logic        charger_on,          // charger running
    input  wire logic        volt_loop_active,    // voltage loop steering output
    // host command port, link clock domain
    input  wire logic        clk_link,
    input  wire logic        cmd_valid,           // one-cycle command strobe
    input  wire logic        cmd_write,           // 1 write, 0 read
    input  wire logic [7:0]  cmd_code,            // command code
    input  wire logic [15:0] cmd_wdata,           // write data, never stored
    output var  logic [15:0] rd_data,             // read answer
    output var  logic        rd_valid,            // one-cycle answer strobe
    // open-drain alert pin
    output var  logic        alert_out,           // level driven when enabled
    output var  logic        alert_oe             // high while pin pulled low
);
    // ---------------- system domain ----------------
    logic [4:0]  sync1;                           // first stage, read only by sync2
    logic [4:0]  sync2;                           // synchronised conditions
    logic        adapter_db;                      // deglitched adapter detect
    logic        volt_db;                         // deglitched voltage loop
    logic [15:0] status;                          // live status word
    logic [15:0] next_status;
    logic        status_chg;                      // some flag about to change
    logic [15:0] xfer_word;                       // word offered to link side
    logic        xfer_req;                        // toggles with each offer
    logic [2:0]  ack_sync;                        // ack toggle from link, [0] first stage
    logic [2:0]  rd_sync;                         // read toggle from link, [0] first stage
    logic        rd_seen;                         // one-cycle: host finished status read
    // link-side state is declared up front because the system side reads its toggles
    logic [2:0]  req_sync;                        // offer toggle, [0] first stage
    logic [15:0] lnk_status;                      // copy of status seen by host
    logic        ack_tgl;                         // toggles when copy taken
    logic        rd_tgl;                          // toggles on each status read
    logic        is_status_rd;                    // read of the status word this cycle

    // two-stage synchronisers for the condition pins
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sync1 <= 5'h00;
            sync2 <= 5'h00;
        end else begin
            sync1 <= {por_done, adapter_det, gate_drive_rail, charger_on, volt_loop_active};
            sync2 <= sync1;
        end
    end

    // adapter and voltage loop bounce in practice, so only they are filtered
    csa_deglitch #(.CYCLES(DEGLITCH_CYCLES), .INIT(1'b0)) u_db_adapter (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .din     (sync2[3]),
        .dout    (adapter_db)
    );
    csa_deglitch #(.CYCLES(DEGLITCH_CYCLES), .INIT(1'b0)) u_db_volt (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .din     (sync2[0]),
        .dout    (volt_db)
    );

    // flag equations; charger_on is left unfiltered so the off flag is immediate
    always_comb begin
        next_status                = READ_ZERO;
        next_status[BIT_NOT_READY] = ~(sync2[4] & adapter_db & sync2[2]);
        next_status[BIT_CHG_OFF]   = ~sync2[1];
        next_status[BIT_VOLT_IDLE] = ~(sync2[1] & volt_db);
    end
    assign status_chg = (next_status != status);

    // status word follows conditions without any host action
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            status <= STATUS_RST;
        end else begin
            status <= next_status;
        end
    end

    // read-done toggle and ack toggle from the link side
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_sync  <= 3'h0;
            ack_sync <= 3'h0;
        end else begin
            rd_sync  <= {rd_sync[1:0], rd_tgl};
            ack_sync <= {ack_sync[1:0], ack_tgl};
        end
    end
    assign rd_seen = rd_sync[2] ^ rd_sync[1];

    // offer a fresh word once the previous offer was taken
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            xfer_word <= STATUS_RST;
            xfer_req  <= 1'b0;
        end else if (xfer_req == ack_sync[1] && xfer_word != status) begin
            xfer_word <= status;                  // held stable until acked
            xfer_req  <= ~xfer_req;
        end
    end

    // alert: a change wins over a read that clears in the same cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            alert_oe <= 1'b0;
        end else if (status_chg) begin
            alert_oe <= 1'b1;
        end else if (rd_seen) begin
            alert_oe <= 1'b0;
        end
    end

    // pin only ever sinks; pull-up outside gives the high level
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            alert_out <= 1'b0;
        end else begin
            alert_out <= 1'b0;
        end
    end

    // ---------------- link domain ----------------

    // take the offered word when its toggle arrives
    always_ff @(posedge clk_link or negedge arst_n) begin
        if (!arst_n) begin
            req_sync   <= 3'h0;
            lnk_status <= STATUS_RST;
            ack_tgl    <= 1'b0;
        end else begin
            req_sync <= {req_sync[1:0], xfer_req};
            if (req_sync[2] != req_sync[1]) begin
                lnk_status <= xfer_word;          // stable since the toggle left
                ack_tgl    <= ~ack_tgl;
            end
        end
    end

    assign is_status_rd = cmd_valid && !cmd_write && cmd_code == CMD_STATUS_WORD;

    // answer reads; writes get no answer and touch nothing
    always_ff @(posedge clk_link or negedge arst_n) begin
        if (!arst_n) begin
            rd_data  <= READ_ZERO;
            rd_valid <= 1'b0;
            rd_tgl   <= 1'b0;
        end else begin
            rd_valid <= cmd_valid && !cmd_write;
            if (is_status_rd) begin
                rd_data <= lnk_status;
                rd_tgl  <= ~rd_tgl;
            end else if (cmd_valid && !cmd_write) begin
                rd_data <= READ_ZERO;             // unknown code reads zero
            end
        end
    end

    // ---------------- checks ----------------
    // two clock domains meet here, so every check names its own clock
    AST_ALERT_ON_CHANGE: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $changed(status) |-> alert_oe)
        else $error("status changed without alert");
    AST_ALERT_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n)
        alert_oe && !rd_seen |=> alert_oe)
        else $error("alert dropped without a status read");
    AST_ALERT_RELEASE: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $fell(alert_oe) |-> $past(rd_seen) && $stable(status))
        else $error("alert released without read");
    AST_NOT_READY: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !status[BIT_NOT_READY] |-> $past(sync2[4] && adapter_db && sync2[2]))
        else $error("ready reported before preconditions");
    AST_OFF_IDLE: assert property (@(posedge clk_sys) disable iff (!arst_n)
        status[BIT_CHG_OFF] |-> status[BIT_VOLT_IDLE])
        else $error("voltage loop active while charger off");
    AST_AUTO_OFF: assert property (@(posedge clk_sys) disable iff (!arst_n)
        sync2[1] ##1 sync2[1] |-> !status[BIT_CHG_OFF])
        else $error("off flag did not follow charger state");
    AST_RESERVED_ZERO: assert property (@(posedge clk_sys) disable iff (!arst_n)
        status[15:FLAG_CNT] == 13'h0000)
        else $error("unused status bits set");
    AST_WRITE_IGNORED: assert property (@(posedge clk_link) disable iff (!arst_n)
        cmd_valid && cmd_write |=> !rd_valid)
        else $error("write produced an answer");
    AST_READ_ANSWER: assert property (@(posedge clk_link) disable iff (!arst_n)
        is_status_rd |=> rd_valid && rd_data == $past(lnk_status))
        else $error("status read answered wrongly");
    AST_PIN_SINK: assert property (@(posedge clk_sys) disable iff (!arst_n)
        alert_out == 1'b0)
        else $error("alert pin driven high");

    CVR_ALERT_SET:  cover property (@(posedge clk_sys) disable iff (!arst_n) $rose(alert_oe));
    CVR_ALERT_CLR:  cover property (@(posedge clk_sys) disable iff (!arst_n) $fell(alert_oe));
    CVR_STATUS_RD:  cover property (@(posedge clk_link) disable iff (!arst_n) is_status_rd);
endmodule
`default_nettype wire

// *** common/csa_pkg.sv ***
// constants shared by the charger status and alert block
package csa_pkg;
    // host command codes
    localparam logic [7:0]  CMD_STATUS_WORD  = 8'h13;      // charger_status_word, read-only
    // status word layout
    localparam int          STATUS_W         = 16;
    localparam int          BIT_NOT_READY    = 0;          // charge_not_ready_flag
    localparam int          BIT_CHG_OFF      = 1;          // charger not on
    localparam int          BIT_VOLT_IDLE    = 2;          // volt_loop_idle_flag
    localparam int          FLAG_CNT         = 3;          // implemented flags, bits above read zero
    // every implemented flag comes up as one
    localparam logic [15:0] STATUS_RST       = 16'h0007;
    localparam logic [15:0] READ_ZERO        = 16'h0000;   // answer to unknown command codes
    // timing
    localparam int          SYS_CLK_HZ       = 25_000_000;
    localparam int          DEGLITCH_US      = 8000;       // 8 ms deglitch
    localparam int          DEGLITCH_CYC     = (SYS_CLK_HZ / 1_000_000) * DEGLITCH_US;
    localparam int          SYNC_STAGES      = 2;
endpackage

// *** logic/csa_deglitch.sv ***
// deglitch filter: output follows input only after it stayed stable for a set time
`timescale 1ns/1ps
`default_nettype none
module csa_deglitch
    import csa_pkg::*;
#(
    parameter int   CYCLES = DEGLITCH_CYC,    // stable cycles before output follows
    parameter logic INIT   = 1'b0             // output value under reset
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic arst_n,
    // filtered level
    input  wire logic din,                    // synchronised raw level
    output var  logic dout                    // deglitched level
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt;                       // cycles the input has differed from the output

    // count while input disagrees, restart on any bounce back
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= '0;
        end else if (din == dout || cnt == LAST) begin
            cnt <= '0;                        // agreement or acceptance both restart the count
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    // take the new level only after the full interval
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dout <= INIT;
        end else if (din != dout && cnt == LAST) begin
            dout <= din;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    AST_DEGLITCH_HOLD: assert property ($changed(dout) |-> $past(cnt) == LAST && $past(din) == dout)
        else $error("deglitch output moved before the interval ran out");
    CVR_DEGLITCH_PASS: cover property ($changed(dout));
endmodule
`default_nettype wire

// *** sim/csa_host_model.sv ***
// host-side model: command strobes on the link clock and the alert pull-up
`timescale 1ns/1ps
`default_nettype none
module csa_host_model (
    // link clock
    input  wire logic        clk_link,
    // command port
    output var  logic        cmd_valid,
    output var  logic        cmd_write,
    output var  logic [7:0]  cmd_code,
    output var  logic [15:0] cmd_wdata,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_valid,
    // alert pin
    input  wire logic        alert_out,
    input  wire logic        alert_oe,
    output wire logic        alert_wire
);
    // pull-up resistor: the wire goes high whenever the device lets go
    assign alert_wire = alert_oe ? alert_out : 1'b1;

    // idle port at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
    end

    // one command strobe; reads wait a few edges for the answer strobe
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] q, output logic got);
        int i;
        got = 1'b0;
        q   = 16'h0000;
        @(negedge clk_link);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_code  = c;
        cmd_wdata = d;
        @(negedge clk_link);
        // released lines show the inverse so stale values never pass
        cmd_valid = 1'b0;
        cmd_code  = ~c;
        cmd_wdata = ~d;
        // the answer strobe rose at the edge that took the command and is settled here
        for (i = 0; i < 3; i++) begin
            if (rd_valid === 1'b1) begin
                got = 1'b1;
                q   = rd_data;
            end
            @(negedge clk_link);
        end
    endtask
endmodule
`default_nettype wire

// *** sim/charger_status_alert_tb_top.sv ***
// self-checking bench for the charger status and alert block
`timescale 1ns/1ps
`default_nettype none
`define CSA_CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module charger_status_alert_tb_top;
    import csa_pkg::*;
    // one table row: {por, adapter, rail, charger_on, volt_loop} and status
    typedef struct packed { logic [4:0] pins; logic [15:0] st; } csa_row_t;
    logic        clk_sys, arst_n, clk_link, cmd_valid, cmd_write, rd_valid;
    logic        por_done, adapter_det, gate_drive_rail, charger_on, volt_loop_active;
    logic        alert_out, alert_oe, alert_wire, got;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata, rd_data, q, prev;
    int          bad_count, n_compared;
    csa_row_t    rows [6] = '{'{5'b11100, 16'h0006}, '{5'b10100, 16'h0007}, '{5'b11110, 16'h0004},
                             '{5'b11111, 16'h0000}, '{5'b11011, 16'h0001}, '{5'b11101, 16'h0006}};

    // short deglitch keeps the run brief
    csa_status_alert #(.DEGLITCH_CYCLES(8)) i_dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .por_done(por_done), .adapter_det(adapter_det),
        .gate_drive_rail(gate_drive_rail), .charger_on(charger_on),
        .volt_loop_active(volt_loop_active), .clk_link(clk_link), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data(rd_data),
        .rd_valid(rd_valid), .alert_out(alert_out), .alert_oe(alert_oe));
    csa_host_model i_host (
        .clk_link(clk_link), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid), .alert_out(alert_out),
        .alert_oe(alert_oe), .alert_wire(alert_wire));

    // 40 ns system clock, 12 ns link clock offset in phase
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        clk_link = 1'b0;
        #3;
        forever #6 clk_link = ~clk_link;
    end

    // verdict in one place
    task automatic close_out;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // condition pins change at the falling edge, then settle time passes
    task automatic set_pins(input logic [4:0] p);
        @(negedge clk_sys);
        {por_done, adapter_det, gate_drive_rail, charger_on, volt_loop_active} = p;
        repeat (20) @(negedge clk_sys);
    endtask

    task automatic rd_status;
        i_host.xfer(1'b0, CMD_STATUS_WORD, 16'h0000, q, got);
        repeat (6) @(negedge clk_sys);
    endtask

    // watchdog: the whole sequence needs well under 30 us
    initial begin
        #100us;
        bad_count++;
        $display("watchdog expired");
        close_out();
    end

    initial begin
        bad_count = 0;
        n_compared = 0;
        arst_n = 1'b0;
        {por_done, adapter_det, gate_drive_rail, charger_on, volt_loop_active} = 5'b00000;
        repeat (3) @(negedge clk_sys);
        `CSA_CHK(alert_oe, 1'b0)
        arst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        rd_status();
        `CSA_CHK(q, STATUS_RST)
        `CSA_CHK(q[BIT_CHG_OFF], 1'b1)
        `CSA_CHK(q[BIT_VOLT_IDLE], 1'b1)
        `CSA_CHK(q[BIT_CHG_OFF] & q[BIT_NOT_READY], 1'b1)
        `CSA_CHK(alert_wire, 1'b1)
        $display("test reset done");
        prev = STATUS_RST;
        // table: each row moves the pins, alert follows any change
        for (int i = 0; i < 6; i++) begin
            set_pins(rows[i].pins);
            `CSA_CHK(alert_oe, rows[i].st != prev)
            `CSA_CHK(alert_wire, 1'b0)
            rd_status();
            `CSA_CHK(q, rows[i].st)
            `CSA_CHK(alert_wire, 1'b1)
            prev = rows[i].st;
            $display("test row %0d done", i);
        end
        // brief adapter dropout is swallowed by the filter
        @(negedge clk_sys);
        adapter_det = 1'b0;
        repeat (4) @(negedge clk_sys);
        adapter_det = 1'b1;
        repeat (20) @(negedge clk_sys);
        `CSA_CHK(alert_oe, 1'b0)
        rd_status();
        `CSA_CHK(q, 16'h0006)
        $display("test glitch done");
        // write and foreign read leave status and alert alone
        set_pins(5'b11111);
        `CSA_CHK(alert_oe, 1'b1)
        i_host.xfer(1'b1, CMD_STATUS_WORD, 16'hFFFF, q, got);
        `CSA_CHK(got, 1'b0)
        i_host.xfer(1'b0, 8'h14, 16'h0000, q, got);
        `CSA_CHK(got, 1'b1)
        repeat (6) @(negedge clk_sys);
        `CSA_CHK(q, READ_ZERO)
        `CSA_CHK(alert_oe, 1'b1)
        // second change while low keeps it low, change after read re-arms
        set_pins(5'b11110);
        `CSA_CHK(alert_oe, 1'b1)
        rd_status();
        `CSA_CHK(q, 16'h0004)
        `CSA_CHK(alert_oe, 1'b0)
        set_pins(5'b11100);
        `CSA_CHK(alert_oe, 1'b1)
        rd_status();
        `CSA_CHK(q, 16'h0006)
        $display("test refuse and rearm done");
        // mid-run reset: power-up word first, ready only after the filter lets adapter through
        @(negedge clk_sys);
        arst_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        `CSA_CHK(alert_oe, 1'b0)
        `CSA_CHK(rd_data, READ_ZERO)
        arst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        i_host.xfer(1'b0, CMD_STATUS_WORD, 16'h0000, q, got);
        `CSA_CHK(q, STATUS_RST)
        `CSA_CHK(alert_oe, 1'b0)
        repeat (20) @(negedge clk_sys);
        `CSA_CHK(alert_oe, 1'b1)
        rd_status();
        `CSA_CHK(q, 16'h0006)
        $display("test mid-run reset done");
        close_out();
    end
endmodule
`default_nettype wire
